// >>> common/rtdc_pkg.sv
package rtdc_pkg;
  // mode codes as delivered by the host when it selects a transceiver mode
  localparam logic [7:0] MODE_FOUR_WIRE = 8'h80;  // 128
  localparam logic [7:0] MODE_TWO_ECHO  = 8'h81;  // 129
  localparam logic [7:0] MODE_TWO_TERM  = 8'h82;  // 130
  localparam logic [7:0] MODE_TWO_AUTO  = 8'h83;  // 131
  localparam int         MODE_W         = 8;

  // internal mode state, binary coded
  typedef enum logic [1:0] {
    RTDC_FOUR = 2'b00,
    RTDC_ECHO = 2'b01,
    RTDC_TERM = 2'b10,
    RTDC_AUTO = 2'b11
  } rtdc_mode_e;

  localparam rtdc_mode_e RESET_MODE = RTDC_FOUR;
endpackage

// >>> verilog/rtdc_ctrl.sv
`timescale 1ns/1ps
module rtdc_ctrl (
  input  wire logic                      I_CLK,                    // uart clock
  input  wire logic                      I_RESET,                  // async, active high
  input  wire logic [rtdc_pkg::MODE_W-1:0] I_MODE_CODE,            // configured mode code
  input  wire logic                      I_PORT_OPEN,              // pulse: port is opened
  input  wire logic                      I_TERMINAL_READY_N,       // uart terminal-ready, active low
  input  wire logic                      I_TRANSMIT_READY_STROBE_N, // uart transmit-ready, active low
  output logic                           O_DRIVER_EN,              // line driver enable
  output logic                           O_RECEIVER_EN,            // line receiver enable
  output logic [1:0]                     O_MODE                    // mode in force
);
  import rtdc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // overview
  // one mode register picks how the two transceiver enables are derived
  // four-wire: both enables held on, control lines ignored
  // echo: driver follows terminal-ready deasserted, receiver stays on
  // term: driver as echo, receiver is its exact opposite
  // auto: driver follows transmit-ready asserted, receiver opposite
  // the mode only moves on an open strobe carrying a known code
  // an unknown code is dropped silently; the old mode stays in force
  // both enables are registered so the pins never glitch while decoding
  // cost of that choice: one clock of lag after any control line change
  // the lag is far below one bit time, so the line is never cut short
  // software must still hold terminal-ready until the last stop bit leaves
  // the block cannot see the shifter, so it cannot guard that itself
  // the mode register and the enable flops share the one asynchronous reset
  // reset lands on four-wire, which is also the mode with no open at all

  //////////////////////////////////////////////////////////////////////////////
  // mode decode
  rtdc_mode_e mode_ff;          // mode in force
  rtdc_mode_e nxt_mode;         // mode picked up at open
  logic       code_valid;       // code is one of the four
  rtdc_mode_e code_mode;        // decoded code

  // unknown codes leave the current mode untouched rather than guessing
  assign code_valid = (I_MODE_CODE == MODE_FOUR_WIRE) || (I_MODE_CODE == MODE_TWO_ECHO) ||
                      (I_MODE_CODE == MODE_TWO_TERM) || (I_MODE_CODE == MODE_TWO_AUTO);
  assign code_mode  = (I_MODE_CODE == MODE_TWO_ECHO) ? RTDC_ECHO :
                      (I_MODE_CODE == MODE_TWO_TERM) ? RTDC_TERM :
                      (I_MODE_CODE == MODE_TWO_AUTO) ? RTDC_AUTO : RTDC_FOUR;
  assign nxt_mode   = (I_PORT_OPEN && code_valid) ? code_mode : mode_ff;

  // mode register, four-wire until something else is opened
  // only a valid open moves it; reset branch assigns the constant alone
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      mode_ff <= RESET_MODE;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // enable logic
  // control lines come from uart logic on this clock, so no synchroniser
  logic term_asserted;   // terminal-ready at logic zero
  logic strobe_asserted; // transmit-ready at logic zero
  logic nxt_driver_en;   // driver enable next
  logic nxt_receiver_en; // receiver enable next

  assign term_asserted   = ~I_TERMINAL_READY_N;
  assign strobe_asserted = ~I_TRANSMIT_READY_STROBE_N;

  // selection per mode; term and echo drive identically, only receiver differs
  always_comb begin
    case (mode_ff)
      RTDC_FOUR: begin
        nxt_driver_en   = 1'b1;
        nxt_receiver_en = 1'b1;
      end
      RTDC_ECHO: begin
        nxt_driver_en   = ~term_asserted;
        nxt_receiver_en = 1'b1;
      end
      RTDC_TERM: begin
        nxt_driver_en   = ~term_asserted;
        nxt_receiver_en = term_asserted;
      end
      RTDC_AUTO: begin
        nxt_driver_en   = strobe_asserted;
        nxt_receiver_en = ~strobe_asserted;
      end
      default: begin
        nxt_driver_en   = 1'b1;
        nxt_receiver_en = 1'b1;
      end
    endcase
  end

  // registered outputs: one clock of latency, never both directions in term or auto mode (echo keeps the receiver on while driving)
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_DRIVER_EN   <= 1'b1;
      O_RECEIVER_EN <= 1'b1;
      O_MODE        <= RESET_MODE;
    end else begin
      O_DRIVER_EN   <= nxt_driver_en;
      O_RECEIVER_EN <= nxt_receiver_en;
      O_MODE        <= mode_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_open_code(logic [7:0] c);
    I_PORT_OPEN && (I_MODE_CODE == c);
  endsequence

  a_four_both_on: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (mode_ff == RTDC_FOUR) |=> (O_DRIVER_EN && O_RECEIVER_EN))
    else $error("four-wire enables not both on");
  a_reset_four: assert property (@(posedge I_CLK) $fell(I_RESET) |-> (mode_ff == RTDC_FOUR))
    else $error("mode not four-wire after reset");
  a_echo_driver: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (mode_ff == RTDC_ECHO) |=> (O_DRIVER_EN == $past(I_TERMINAL_READY_N)))
    else $error("echo driver wrong");
  a_echo_recv_on: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (mode_ff == RTDC_ECHO) |=> O_RECEIVER_EN)
    else $error("echo receiver off");
  a_term_no_echo: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (mode_ff == RTDC_TERM) |=> (O_RECEIVER_EN == !$past(I_TERMINAL_READY_N)) && (O_RECEIVER_EN != O_DRIVER_EN))
    else $error("term receiver wrong");
  a_auto_follow: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (mode_ff == RTDC_AUTO) |=> (O_DRIVER_EN == !$past(I_TRANSMIT_READY_STROBE_N)))
    else $error("auto driver wrong");
  a_auto_no_echo: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (mode_ff == RTDC_AUTO) |=> (O_RECEIVER_EN != O_DRIVER_EN))
    else $error("auto echo not suppressed");
  a_code_auto: assert property (@(posedge I_CLK) disable iff (I_RESET)
    s_open_code(MODE_TWO_AUTO) |=> (mode_ff == RTDC_AUTO) ##1 (O_MODE == RTDC_AUTO))
    else $error("code 131 not auto");
  a_hold_closed: assert property (@(posedge I_CLK) disable iff (I_RESET)
    !I_PORT_OPEN |=> $stable(mode_ff))
    else $error("mode changed without open");

  //////////////////////////////////////////////////////////////////////////////
  // further mode loading checks
  // every documented code must land in its own state one edge after open
  // a broken decode that aliased two codes would trip one of these
  a_code_four: assert property (@(posedge I_CLK) disable iff (I_RESET)
    s_open_code(MODE_FOUR_WIRE) |=> (mode_ff == RTDC_FOUR))
    else $error("code 128 not four-wire");
  a_code_echo: assert property (@(posedge I_CLK) disable iff (I_RESET)
    s_open_code(MODE_TWO_ECHO) |=> (mode_ff == RTDC_ECHO))
    else $error("code 129 not echo");
  a_code_term: assert property (@(posedge I_CLK) disable iff (I_RESET)
    s_open_code(MODE_TWO_TERM) |=> (mode_ff == RTDC_TERM))
    else $error("code 130 not term");

  // an open with an unknown code must not disturb the mode in force
  a_bad_code_keep: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (I_PORT_OPEN && !code_valid) |=> $stable(mode_ff))
    else $error("unknown code changed mode");

  // the reported mode trails the internal one by exactly one edge
  a_mode_out_lag: assert property (@(posedge I_CLK) disable iff (I_RESET)
    1'b1 |=> (O_MODE == $past(mode_ff)))
    else $error("reported mode out of step");

  //////////////////////////////////////////////////////////////////////////////
  // enable checks not covered above
  // term mode drives exactly like echo mode; only the receiver differs
  a_term_driver: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (mode_ff == RTDC_TERM) |=> (O_DRIVER_EN == $past(I_TERMINAL_READY_N)))
    else $error("term driver wrong");

  // auto receiver must be the plain level of the active-low strobe
  a_auto_recv: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (mode_ff == RTDC_AUTO) |=> (O_RECEIVER_EN == $past(I_TRANSMIT_READY_STROBE_N)))
    else $error("auto receiver wrong");

  // a strobe asserted then released in auto mode turns the line round
  // two steps, so they are spelt out as a sequence
  sequence s_auto_byte;
    (mode_ff == RTDC_AUTO) && !I_TRANSMIT_READY_STROBE_N ##1
    (mode_ff == RTDC_AUTO) && I_TRANSMIT_READY_STROBE_N;
  endsequence

  a_auto_turn: assert property (@(posedge I_CLK) disable iff (I_RESET)
    s_auto_byte |=> (!O_DRIVER_EN && O_RECEIVER_EN && $fell(O_DRIVER_EN)))
    else $error("auto turnaround wrong");
endmodule

// >>> testbench/rtdc_xcvr_model.sv
`timescale 1ns/1ps
// bus carries our bit while we drive, else a remote node's bit
module rtdc_xcvr_model (
  input  wire logic i_drv_en,  // local driver enable
  input  wire logic i_rcv_en,  // local receiver enable
  input  wire logic i_tx_bit,  // local transmit bit
  input  wire logic i_far_bit, // remote node bit
  output logic      o_rx_bit   // bit at local receiver
);
  wire logic line = i_drv_en ? i_tx_bit : i_far_bit; // shared pair
  // a disabled receiver floats; show the inverse so a stale value never matches
  assign o_rx_bit = i_rcv_en ? line : ~line;
endmodule

// >>> testbench/rtdc_ctrl_tb.sv
`timescale 1ns/1ps
module rtdc_ctrl_tb;
  import rtdc_pkg::*;
  logic       clk, rst, opn, trn, txn, tx, far; // bench drives
  logic [7:0] code;                             // mode code
  logic       de, re, rx;                       // observed enables, echo
  logic [1:0] md;                               // mode in force
  int         num_errors = 0, compares = 0;
  rtdc_ctrl DUT (.I_CLK(clk), .I_RESET(rst), .I_MODE_CODE(code), .I_PORT_OPEN(opn), .I_TERMINAL_READY_N(trn),
    .I_TRANSMIT_READY_STROBE_N(txn), .O_DRIVER_EN(de), .O_RECEIVER_EN(re), .O_MODE(md));
  rtdc_xcvr_model PEER (.i_drv_en(de), .i_rcv_en(re), .i_tx_bit(tx), .i_far_bit(far), .o_rx_bit(rx));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [1:0] e, logic [1:0] s);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask
  // inputs change at falling edges; two rising edges cover the registered latency
  task automatic step(logic t, logic x);
    trn = t; txn = x; repeat (2) @(negedge clk);
  endtask
  task automatic open(logic [7:0] c);
    code = c; opn = 1; @(negedge clk); opn = 0; @(negedge clk);
  endtask
  task automatic en(logic d, logic r);
    chk("drv_en", d, de); chk("rcv_en", r, re);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_four;
    en(1, 1); chk("mode", 0, md);
    step(0, 0); en(1, 1);
  endtask
  task automatic t_echo;
    open(MODE_TWO_ECHO);
    step(1, 1);
    en(1, 1);
    tx = 1; far = 0; #1 chk("echo", tx, rx);
    @(negedge clk);
    step(0, 1);
    en(0, 1); chk("mode", 1, md);
  endtask
  task automatic t_term;
    open(MODE_TWO_TERM); step(1, 1); en(1, 0);
    tx = 0; #1 chk("no_echo", !tx, rx);
    @(negedge clk);
    step(0, 0); en(0, 1); chk("mode", 2, md);
    far = 1; #1 chk("far", far, rx);
    @(negedge clk);
  endtask
  task automatic t_auto;
    open(MODE_TWO_AUTO);
    step(1, 0); en(1, 0);
    step(0, 1); en(0, 1); chk("mode", 3, md);
  endtask
  task automatic t_bad;
    open(8'h84); chk("mode", 3, md);
    open(MODE_FOUR_WIRE); step(0, 0); en(1, 1);
  endtask
  task automatic wrap_up;
    if (num_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #3000; num_errors++; wrap_up();
  end
  initial begin
    rst = 1; opn = 0; code = MODE_FOUR_WIRE; trn = 1; txn = 1; tx = 0; far = 0;
    repeat (10) @(negedge clk);
    rst = 0; @(negedge clk);
    t_four(); t_echo(); t_term(); t_auto(); t_bad();
    wrap_up();
  end
endmodule
